// ==== src/jtdp_pkg.sv ====
package jtdp_pkg;
   // Instruction and data register widths.
   localparam int IR_W = 4;
   localparam int DR_W = 32;
   // Instruction codes.
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_CHIP_IDENTITY_WORD = 4'h1;
   localparam logic [3:0] OP_SAMPLE = 4'h2;
   localparam logic [3:0] OP_USER = 4'h8;
   localparam logic [3:0] OP_CHIP = 4'h9;
   localparam logic [3:0] OP_BYPASS = 4'hf;
   // Value loaded into the instruction shifter on capture; low bits 01 as the standard wants.
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   // Identification word fields; these values are arbitrary.
   localparam logic [3:0] ID_VERSION = 4'h0;
   localparam logic [15:0] ID_PART = 16'h0001;
   localparam logic [10:0] ID_MAKER = 11'h001;
   localparam logic ID_MARKER = 1'b1;
   // User word layout: identifier bits 31..22, unused 21..16, revision 15..0.
   localparam int UID_HI = 31;
   localparam int UID_LO = 22;
   localparam logic [5:0] USER_UNUSED = 6'h00;
   localparam logic [15:0] SI_REVISION = 16'h0000;
   // Security register bits.
   localparam int SEC_NO_JTAG = 0;
   localparam int SEC_NO_JTAG_OTP = 13;
   localparam int SEC_NO_DEBUG = 14;
   // Debug pin modes set by software.
   localparam logic [1:0] DBG_IGNORE = 2'h0;
   localparam logic [1:0] DBG_OUTPUT = 2'h1;
   localparam logic [1:0] DBG_INPUT = 2'h2;
   // Synchroniser lane order and reset levels: tck, tms, tdi, trst_n, debug_n, pll lock.
   localparam int S_TCK = 0;
   localparam int S_TMS = 1;
   localparam int S_TDI = 2;
   localparam int S_TRST = 3;
   localparam int S_DBG = 4;
   localparam int S_LOCK = 5;
   localparam int SYNC_W = 6;
   localparam logic [5:0] SYNC_RST = 6'h12;
   // Controller states, one-hot.
   typedef enum logic [15:0] {
      ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
      ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
      ST_UP_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UP_IR = 16'h8000
   } jtdp_state_e;
endpackage : jtdp_pkg

// ==== src/jtdp_port.sv ====
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////
module jtdp_port #(
   parameter int NUM_IO = 8
) (
   // Clock and global reset.
   input wire logic clk_in,
   input wire logic rstn_in,
   // Test port pins.
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   input wire logic trst_n_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   // Debug synchronisation pin.
   input wire logic debug_n_in,
   output logic debug_n_out,
   output logic debug_n_oe_out,
   // Processor tile side.
   input wire logic [31:0] sec_reg_in,
   input wire logic [1:0] dbg_mode_in,
   input wire logic breakpoint_in,
   output logic debug_req_out,
   output logic otp_block_out,
   // Boot control.
   input wire logic pll_lock_in,
   input wire logic [2:0] boot_mode_in,
   output logic boot_go_out,
   output logic [2:0] boot_mode_out,
   // Internal chip port.
   input wire logic chip_tdo_in,
   output logic chip_sel_out,
   output logic chip_capture_out,
   output logic chip_shift_out,
   output logic chip_update_out,
   output logic chip_tdi_out,
   // Boundary cells.
   input wire logic [NUM_IO-1:0] pad_in,
   output logic [NUM_IO-1:0] pad_out,
   output logic extest_out
);
   //////////////////////////////////////////////////////////////////////////////////////
   // Synchronised pins.
   logic [jtdp_pkg::SYNC_W-1:0] sync_q;
   logic tck_s, tms_s, tdi_s, trst_s, dbg_s, lock_s;

   jtdp_sync #(.W(jtdp_pkg::SYNC_W), .RST_VAL(jtdp_pkg::SYNC_RST)) u_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .d_in({pll_lock_in, debug_n_in, trst_n_in, tdi_in, tms_in, tck_in}),
      .q_out(sync_q)
   );

   // Names for the synchronised lanes.
   assign tck_s = sync_q[jtdp_pkg::S_TCK];
   assign tms_s = sync_q[jtdp_pkg::S_TMS];
   assign tdi_s = sync_q[jtdp_pkg::S_TDI];
   assign trst_s = sync_q[jtdp_pkg::S_TRST];
   assign dbg_s = sync_q[jtdp_pkg::S_DBG];
   assign lock_s = sync_q[jtdp_pkg::S_LOCK];

   //////////////////////////////////////////////////////////////////////////////////////
   // Test clock edges and controller.
   logic tck_q, next_tck_q;
   logic tck_rise, tck_fall, tap_hold;
   jtdp_pkg::jtdp_state_e state, next_state;

   // The test clock is slow enough to be sampled; edges are found from the synchronised copy.
   assign tck_rise = tck_s & ~tck_q;
   assign tck_fall = ~tck_s & tck_q;
   // A low test reset or the security lock keeps the port in its reset state.
   assign tap_hold = ~trst_s | sec_reg_in[jtdp_pkg::SEC_NO_JTAG];

   // Standard state walk on each rising test clock edge.
   always_comb begin
      next_tck_q = tck_s;
      next_state = state;
      if (tap_hold) begin
         next_state = jtdp_pkg::ST_TLR;
      end else if (tck_rise) begin
         case (state)
            jtdp_pkg::ST_TLR: next_state = tms_s ? jtdp_pkg::ST_TLR : jtdp_pkg::ST_RTI;
            jtdp_pkg::ST_RTI: next_state = tms_s ? jtdp_pkg::ST_SEL_DR : jtdp_pkg::ST_RTI;
            jtdp_pkg::ST_SEL_DR: next_state = tms_s ? jtdp_pkg::ST_SEL_IR : jtdp_pkg::ST_CAP_DR;
            jtdp_pkg::ST_CAP_DR: next_state = tms_s ? jtdp_pkg::ST_EX1_DR : jtdp_pkg::ST_SH_DR;
            jtdp_pkg::ST_SH_DR: next_state = tms_s ? jtdp_pkg::ST_EX1_DR : jtdp_pkg::ST_SH_DR;
            jtdp_pkg::ST_EX1_DR: next_state = tms_s ? jtdp_pkg::ST_UP_DR : jtdp_pkg::ST_PA_DR;
            jtdp_pkg::ST_PA_DR: next_state = tms_s ? jtdp_pkg::ST_EX2_DR : jtdp_pkg::ST_PA_DR;
            jtdp_pkg::ST_EX2_DR: next_state = tms_s ? jtdp_pkg::ST_UP_DR : jtdp_pkg::ST_SH_DR;
            jtdp_pkg::ST_UP_DR: next_state = tms_s ? jtdp_pkg::ST_SEL_DR : jtdp_pkg::ST_RTI;
            jtdp_pkg::ST_SEL_IR: next_state = tms_s ? jtdp_pkg::ST_TLR : jtdp_pkg::ST_CAP_IR;
            jtdp_pkg::ST_CAP_IR: next_state = tms_s ? jtdp_pkg::ST_EX1_IR : jtdp_pkg::ST_SH_IR;
            jtdp_pkg::ST_SH_IR: next_state = tms_s ? jtdp_pkg::ST_EX1_IR : jtdp_pkg::ST_SH_IR;
            jtdp_pkg::ST_EX1_IR: next_state = tms_s ? jtdp_pkg::ST_UP_IR : jtdp_pkg::ST_PA_IR;
            jtdp_pkg::ST_PA_IR: next_state = tms_s ? jtdp_pkg::ST_EX2_IR : jtdp_pkg::ST_PA_IR;
            jtdp_pkg::ST_EX2_IR: next_state = tms_s ? jtdp_pkg::ST_UP_IR : jtdp_pkg::ST_SH_IR;
            jtdp_pkg::ST_UP_IR: next_state = tms_s ? jtdp_pkg::ST_SEL_DR : jtdp_pkg::ST_RTI;
            default: next_state = jtdp_pkg::ST_TLR;
         endcase
      end
   end

   // Registers the controller.
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         tck_q <= 1'b0;
         state <= jtdp_pkg::ST_TLR;
      end else begin
         tck_q <= next_tck_q;
         state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Instruction and data shifters.
   logic [jtdp_pkg::IR_W-1:0] ir, next_ir, ir_sh, next_ir_sh;
   logic [jtdp_pkg::DR_W-1:0] dr_sh, next_dr_sh;
   logic [NUM_IO-1:0] bsr_sh, next_bsr_sh, next_pad_out;
   logic byp, next_byp, next_extest, scan_bit;
   logic [jtdp_pkg::DR_W-1:0] id_word, user_word;
   logic sel_word, sel_bsr, sel_chip;

   // Identity and user words; a blank fuse area reads as a zero identifier.
   assign id_word = {jtdp_pkg::ID_VERSION, jtdp_pkg::ID_PART, jtdp_pkg::ID_MAKER,
                     jtdp_pkg::ID_MARKER};
   assign user_word = {sec_reg_in[jtdp_pkg::UID_HI:jtdp_pkg::UID_LO], jtdp_pkg::USER_UNUSED,
                       jtdp_pkg::SI_REVISION};
   assign sel_word = (ir == jtdp_pkg::OP_CHIP_IDENTITY_WORD) || (ir == jtdp_pkg::OP_USER);
   assign sel_bsr = (ir == jtdp_pkg::OP_EXTEST) || (ir == jtdp_pkg::OP_SAMPLE);
   assign sel_chip = (ir == jtdp_pkg::OP_CHIP);

   // Capture and shift of the local chains, update of the instruction and boundary registers; shifting is LSB first from TDI.
   always_comb begin
      next_ir = ir;
      next_ir_sh = ir_sh;
      next_dr_sh = dr_sh;
      next_bsr_sh = bsr_sh;
      next_pad_out = pad_out;
      next_byp = byp;
      next_extest = (ir == jtdp_pkg::OP_EXTEST);
      if (state == jtdp_pkg::ST_TLR) begin
         next_ir = jtdp_pkg::OP_CHIP_IDENTITY_WORD;
      end else if (tck_rise) begin
         case (state)
            jtdp_pkg::ST_CAP_IR: next_ir_sh = jtdp_pkg::IR_CAPTURE;
            jtdp_pkg::ST_SH_IR: next_ir_sh = {tdi_s, ir_sh[jtdp_pkg::IR_W-1:1]};
            jtdp_pkg::ST_CAP_DR: begin
               next_byp = 1'b0;
               next_bsr_sh = pad_in;
               if (ir == jtdp_pkg::OP_USER) begin
                  next_dr_sh = user_word;
               end else begin
                  next_dr_sh = id_word;
               end
            end
            jtdp_pkg::ST_SH_DR: begin
               next_byp = tdi_s;
               if (sel_word) begin
                  next_dr_sh = {tdi_s, dr_sh[jtdp_pkg::DR_W-1:1]};
               end
               if (sel_bsr) begin
                  next_bsr_sh = {tdi_s, bsr_sh[NUM_IO-1:1]};
               end
            end
            default: begin
            end
         endcase
      end else if (tck_fall) begin
         // Updates happen on the falling edge, as the standard places them.
         if (state == jtdp_pkg::ST_UP_IR) begin
            next_ir = ir_sh;
         end
         if (state == jtdp_pkg::ST_UP_DR && sel_bsr) begin
            next_pad_out = bsr_sh;
         end
      end
   end

   // Registers the chains.
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ir <= jtdp_pkg::OP_CHIP_IDENTITY_WORD;
         ir_sh <= jtdp_pkg::IR_CAPTURE;
         dr_sh <= '0;
         bsr_sh <= '0;
         pad_out <= '0;
         byp <= 1'b0;
         extest_out <= 1'b0;
      end else begin
         ir <= next_ir;
         ir_sh <= next_ir_sh;
         dr_sh <= next_dr_sh;
         bsr_sh <= next_bsr_sh;
         pad_out <= next_pad_out;
         byp <= next_byp;
         extest_out <= next_extest;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Serial output and chip port.
   logic next_tdo, next_tdo_oe, next_sel, next_cap, next_shift, next_upd, next_ctdi;

   // Picks the bit that leaves on TDO for the current chain.
   always_comb begin
      if (state == jtdp_pkg::ST_SH_IR) begin
         scan_bit = ir_sh[0];
      end else if (sel_word) begin
         scan_bit = dr_sh[0];
      end else if (sel_bsr) begin
         scan_bit = bsr_sh[0];
      end else if (sel_chip) begin
         scan_bit = chip_tdo_in;
      end else begin
         scan_bit = byp;
      end
   end

   // TDO changes on the falling edge so the host samples a settled bit on the next rise.
   always_comb begin
      next_tdo = tdo_out;
      next_tdo_oe = tdo_oe_out;
      if (tck_fall) begin
         next_tdo = scan_bit;
         next_tdo_oe = (state == jtdp_pkg::ST_SH_IR) || (state == jtdp_pkg::ST_SH_DR);
      end
      // A held port stops driving at once, even if the host has parked the test clock.
      if (tap_hold) begin
         next_tdo_oe = 1'b0;
      end
      next_sel = sel_chip && !tap_hold;
      next_cap = next_sel && tck_rise && (state == jtdp_pkg::ST_CAP_DR);
      next_shift = next_sel && tck_rise && (state == jtdp_pkg::ST_SH_DR);
      next_upd = next_sel && tck_fall && (state == jtdp_pkg::ST_UP_DR);
      next_ctdi = next_shift ? tdi_s : chip_tdi_out;
   end

   // Registers the serial output and chip port strobes.
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
         chip_sel_out <= 1'b0;
         chip_capture_out <= 1'b0;
         chip_shift_out <= 1'b0;
         chip_update_out <= 1'b0;
         chip_tdi_out <= 1'b0;
      end else begin
         tdo_out <= next_tdo;
         tdo_oe_out <= next_tdo_oe;
         chip_sel_out <= next_sel;
         chip_capture_out <= next_cap;
         chip_shift_out <= next_shift;
         chip_update_out <= next_upd;
         chip_tdi_out <= next_ctdi;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Debug pin, OTP lock and boot.
   logic dbg_lock, dbg_q, next_dbg_q;
   logic next_dbg_oe, next_dbg_req, next_otp_block, next_boot_go;
   logic [2:0] next_boot_mode;

   assign dbg_lock = sec_reg_in[jtdp_pkg::SEC_NO_DEBUG];

   // Output mode pulls the line low while stopped; input mode turns a falling line into
   // a request. The pin is only read in input mode so our own drive never loops back.
   always_comb begin
      next_dbg_q = dbg_s;
      next_dbg_oe = !dbg_lock && (dbg_mode_in == jtdp_pkg::DBG_OUTPUT)
                    && breakpoint_in;
      next_dbg_req = !dbg_lock && (dbg_mode_in == jtdp_pkg::DBG_INPUT)
                     && dbg_q && !dbg_s;
      next_otp_block = sec_reg_in[jtdp_pkg::SEC_NO_JTAG_OTP]
                       || sec_reg_in[jtdp_pkg::SEC_NO_JTAG];
      // Boot waits for lock after reset, then holds; the strap is caught at that moment.
      next_boot_go = boot_go_out || lock_s;
      next_boot_mode = (!boot_go_out && lock_s) ? boot_mode_in : boot_mode_out;
   end

   // Registers the debug and boot state; the global reset clears boot until lock returns.
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         dbg_q <= 1'b1;
         debug_n_out <= 1'b0;
         debug_n_oe_out <= 1'b0;
         debug_req_out <= 1'b0;
         otp_block_out <= 1'b1;
         boot_go_out <= 1'b0;
         boot_mode_out <= 3'h0;
      end else begin
         dbg_q <= next_dbg_q;
         debug_n_out <= 1'b0;
         debug_n_oe_out <= next_dbg_oe;
         debug_req_out <= next_dbg_req;
         otp_block_out <= next_otp_block;
         boot_go_out <= next_boot_go;
         boot_mode_out <= next_boot_mode;
      end
   end
endmodule : jtdp_port

// ==== src/jtdp_sync.sv ====
`timescale 1ns/10ps
// Two-stage synchroniser; only the second stage is visible outside.
module jtdp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rstn_in,
   // Data.
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // The first stage feeds the second stage and nothing else.
   always_comb begin
      next_meta = d_in;
      next_q = meta;
   end

   // Registers both stages.
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         meta <= RST_VAL;
         q_out <= RST_VAL;
      end else begin
         meta <= next_meta;
         q_out <= next_q;
      end
   end
endmodule : jtdp_sync

// ==== tb/jtdp_host.sv ====
`timescale 1ns/10ps
// Test host: one link bit per eight system clocks, link clock idle low.
module jtdp_host (
   // System clock.
   input wire logic clk_in,
   // Link pins.
   input wire logic tdo_in,
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   output logic trst_n_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Test reset starts low so the port is held through power-up.
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
      trst_n_out = 1'b0;
   end
   // Drive the test reset level.
   task set_trst(input logic lvl);
      @(posedge clk_in);
      trst_n_out <= lvl;
   endtask : set_trst
   // Four clocks low, four high; tdo is read mid-high, clear of its update.
   task bit_io(input logic tms, input logic tdi, output logic tdo);
      @(posedge clk_in);
      tms_out <= tms;
      tdi_out <= tdi;
      repeat (3) @(posedge clk_in);
      tck_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      tdo = tdo_in;
      repeat (2) @(posedge clk_in);
      tck_out <= 1'b0;
   endtask : bit_io
endmodule : jtdp_host

// ==== tb/jtdp_port_sva.sv ====
`timescale 1ns/10ps
// Pin-level checks on the test port; it only sees the top-level ports.
module jtdp_port_sva (
   // Clock and resets.
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic trst_n_in,
   // Tile side and pins.
   input wire logic debug_n_in,
   input wire logic [31:0] sec_reg_in,
   input wire logic [1:0] dbg_mode_in,
   input wire logic breakpoint_in,
   input wire logic pll_lock_in,
   // Watched outputs.
   input wire logic tdo_oe_out,
   input wire logic debug_n_out,
   input wire logic debug_n_oe_out,
   input wire logic debug_req_out,
   input wire logic otp_block_out,
   input wire logic boot_go_out,
   input wire logic chip_sel_out,
   input wire logic chip_shift_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Everything runs on the system clock and rests while global reset is low.
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   // Debug pin checks; waits allow for the two-flop pin synchroniser.
   AST_DBG_DRIVE: assert property (
      (dbg_mode_in == jtdp_pkg::DBG_OUTPUT && breakpoint_in && !sec_reg_in[14])
      |=> debug_n_oe_out && !debug_n_out) else $error("debug pin not driven low");
   AST_DBG_TRISTATE: assert property (
      debug_n_oe_out |-> $past(breakpoint_in) && $past(dbg_mode_in) == jtdp_pkg::DBG_OUTPUT)
      else $error("debug pin driven without breakpoint");
   AST_DBG_LOCK: assert property (
      sec_reg_in[14] [*4] |-> !debug_n_oe_out && !debug_req_out)
      else $error("debug pin active while locked");
   AST_DBG_REQ: assert property (
      $fell(debug_n_in) && dbg_mode_in == jtdp_pkg::DBG_INPUT && !sec_reg_in[14]
      |-> ##[2:4] debug_req_out) else $error("debug request missing");
   AST_DBG_IGNORE: assert property (
      (dbg_mode_in != jtdp_pkg::DBG_INPUT) [*4] |-> !debug_req_out)
      else $error("debug request outside input mode");
   AST_REQ_PULSE: assert property (debug_req_out |=> !debug_req_out)
      else $error("debug request longer than one cycle");
   // Security bits, test reset, boot and the chip shift pulse.
   AST_OTP_BLOCK: assert property (sec_reg_in[13] || sec_reg_in[0] |=> otp_block_out)
      else $error("otp access not blocked");
   AST_SEC_OFF: assert property (sec_reg_in[0] [*4] |-> !tdo_oe_out && !chip_sel_out)
      else $error("test port active while disabled");
   AST_TRST_HOLD: assert property (!trst_n_in [*6] |-> !tdo_oe_out && !chip_sel_out)
      else $error("test port active in test reset");
   AST_BOOT_LOCK: assert property ($rose(boot_go_out) |-> $past(pll_lock_in, 2))
      else $error("boot started before lock");
   AST_BOOT_GO: assert property ($rose(pll_lock_in) |-> ##[2:4] boot_go_out)
      else $error("boot late after lock");
   AST_CHIP_SHIFT: assert property (chip_shift_out |-> chip_sel_out ##1 !chip_shift_out)
      else $error("chip shift pulse bad");
   // Main scenarios reached.
   cover property ($rose(boot_go_out));
   cover property (debug_req_out);
   cover property (chip_shift_out);
   cover property (debug_n_oe_out);
endmodule : jtdp_port_sva

bind jtdp_port jtdp_port_sva chk_u (.clk_in, .rstn_in, .trst_n_in, .debug_n_in, .sec_reg_in,
   .dbg_mode_in, .breakpoint_in, .pll_lock_in, .tdo_oe_out, .debug_n_out, .debug_n_oe_out,
   .debug_req_out, .otp_block_out, .boot_go_out, .chip_sel_out, .chip_shift_out);

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
   logic clk_in, rstn_in, tck_in, tms_in, tdi_in, trst_n_in, tdo_out, tdo_oe_out, b, clr;
   logic debug_n_out, debug_n_oe_out, ext_low, breakpoint_in, debug_req_out, otp_block_out;
   logic pll_lock_in, boot_go_out, chip_tdo_in, chip_sel_out, chip_capture_out, chip_shift_out;
   logic chip_update_out, chip_tdi_out, extest_out;
   logic [31:0] sec_reg_in, q;
   logic [1:0] dbg_mode_in;
   logic [2:0] boot_mode_in, boot_mode_out;
   logic [7:0] pad_in, pad_out, chip_rx, n_req, n_cap, n_sh, n_up, n_oe;
   int n_mismatch, num_checks, cyc;
   // Debug pin has a pull-up; the device or the bench may pull it low.
   wire debug_n_in = debug_n_oe_out ? debug_n_out : !ext_low;
   ////////////////////////////////////////////////////////////////////////////////
   // Host model and device.
   jtdp_host host_u (.clk_in, .tdo_in(tdo_out), .tck_out(tck_in), .tms_out(tms_in),
      .tdi_out(tdi_in), .trst_n_out(trst_n_in));
   jtdp_port #(.NUM_IO(8)) dut_u (.clk_in, .rstn_in, .tck_in, .tms_in, .tdi_in, .trst_n_in,
      .tdo_out, .tdo_oe_out, .debug_n_in, .debug_n_out, .debug_n_oe_out, .sec_reg_in,
      .dbg_mode_in, .breakpoint_in, .debug_req_out, .otp_block_out, .pll_lock_in,
      .boot_mode_in, .boot_go_out, .boot_mode_out, .chip_tdo_in, .chip_sel_out,
      .chip_capture_out, .chip_shift_out, .chip_update_out, .chip_tdi_out, .pad_in, .pad_out,
      .extest_out);
   // Clock.
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   // Pulse counters; a seen-flag for tdo enable so a long run cannot wrap to zero.
   always @(posedge clk_in) begin
      if (clr) begin
         {n_req, n_cap, n_sh, n_up, n_oe} <= '0;
      end else begin
         n_req <= n_req + 8'(debug_req_out);
         n_cap <= n_cap + 8'(chip_capture_out);
         n_sh <= n_sh + 8'(chip_shift_out);
         n_up <= n_up + 8'(chip_update_out);
         n_oe <= n_oe | 8'(tdo_oe_out);
         if (chip_shift_out) chip_rx <= {chip_tdi_out, chip_rx[7:1]};
      end
   end
   // Hang guard well above the expected run of a few thousand cycles.
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task complete_run;
      if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wait_clk(input int n);
      repeat (n) @(posedge clk_in);
   endtask : wait_clk
   task clear_cnt;
      clr <= 1'b1;
      wait_clk(1);
      clr <= 1'b0;
   endtask : clear_cnt
   // From idle: pick the path, shift n bits LSB first, update, back to idle.
   task xfer(input logic ir, input int n, input logic [31:0] d, output logic [31:0] r);
      host_u.bit_io(1'b1, 1'b0, b);
      if (ir) host_u.bit_io(1'b1, 1'b0, b);
      host_u.bit_io(1'b0, 1'b0, b);
      host_u.bit_io(1'b0, 1'b0, b);
      r = '0;
      for (int i = 0; i < n; i++) begin
         host_u.bit_io(i == n - 1, d[i], b);
         r[i] = b;
      end
      host_u.bit_io(1'b1, 1'b0, b);
      host_u.bit_io(1'b0, 1'b0, b);
   endtask : xfer
   task tap_reset;
      repeat (5) host_u.bit_io(1'b1, 1'b0, b);
      host_u.bit_io(1'b0, 1'b0, b);
   endtask : tap_reset
   // Hold a mode, pull the debug pin low briefly, then release it.
   task pulse_dbg(input logic [1:0] mode);
      dbg_mode_in <= mode;
      clear_cnt();
      wait_clk(4);
      ext_low <= 1'b1;
      wait_clk(6);
      ext_low <= 1'b0;
      wait_clk(6);
   endtask : pulse_dbg
   // Main sequence.
   initial begin
      {rstn_in, ext_low, breakpoint_in, pll_lock_in, chip_tdo_in} = '0;
      {boot_mode_in, pad_in, clr} = '1;
      sec_reg_in = '0;
      dbg_mode_in = jtdp_pkg::DBG_IGNORE;
      wait_clk(12);
      chk({31'h0, otp_block_out}, 32'h1);
      chk({30'h0, tdo_oe_out, boot_go_out}, 32'h0);
      rstn_in <= 1'b1;
      boot_mode_in <= 3'h5;
      clr <= 1'b0;
      wait_clk(4);
      chk({31'h0, boot_go_out}, 32'h0);
      pll_lock_in <= 1'b1;
      wait_clk(6);
      chk({28'h0, boot_go_out, boot_mode_out}, 32'hd);
      tap_reset();
      xfer(1'b0, 32, 32'h0, q);
      chk({24'h0, n_oe}, 32'h0);
      host_u.set_trst(1'b1);
      wait_clk(4);
      tap_reset();
      xfer(1'b1, 4, 32'(jtdp_pkg::OP_BYPASS), q);
      chk(q, 32'(jtdp_pkg::IR_CAPTURE));
      xfer(1'b0, 32, 32'h1234abcd, q);
      chk(q, 32'h1234abcd << 1);
      host_u.set_trst(1'b0);
      wait_clk(4);
      host_u.set_trst(1'b1);
      wait_clk(4);
      host_u.bit_io(1'b0, 1'b0, b);
      xfer(1'b0, 32, 32'h0, q);
      chk(q, {jtdp_pkg::ID_VERSION, jtdp_pkg::ID_PART, jtdp_pkg::ID_MAKER, 1'b1});
      sec_reg_in <= 32'ha9400000;
      xfer(1'b1, 4, 32'(jtdp_pkg::OP_USER), q);
      xfer(1'b0, 32, 32'h0, q);
      chk(q, {10'h2a5, jtdp_pkg::USER_UNUSED, jtdp_pkg::SI_REVISION});
      sec_reg_in <= 32'h0;
      pad_in <= 8'h5a;
      xfer(1'b1, 4, 32'(jtdp_pkg::OP_SAMPLE), q);
      xfer(1'b0, 8, 32'h0, q);
      chk(q, 32'h5a);
      xfer(1'b1, 4, 32'(jtdp_pkg::OP_EXTEST), q);
      xfer(1'b0, 8, 32'hc3, q);
      chk({23'h0, extest_out, pad_out}, 32'h1c3);
      chip_tdo_in <= 1'b1;
      clear_cnt();
      xfer(1'b1, 4, 32'(jtdp_pkg::OP_CHIP), q);
      xfer(1'b0, 8, 32'h96, q);
      chk(q, 32'hff);
      chk({n_cap, n_sh, n_up, chip_rx}, 32'h01080196);
      chk({24'h0, n_oe}, 32'h1);
      sec_reg_in <= 32'h1;
      wait_clk(3);
      chk({31'h0, otp_block_out}, 32'h1);
      clear_cnt();
      tap_reset();
      xfer(1'b0, 32, 32'h0, q);
      chk({24'h0, n_oe}, 32'h0);
      sec_reg_in <= 32'h2000;
      wait_clk(3);
      chk({31'h0, otp_block_out}, 32'h1);
      sec_reg_in <= 32'h0;
      dbg_mode_in <= jtdp_pkg::DBG_OUTPUT;
      wait_clk(3);
      chk({30'h0, otp_block_out, debug_n_in}, 32'h1);
      breakpoint_in <= 1'b1;
      wait_clk(3);
      chk({31'h0, debug_n_in}, 32'h0);
      sec_reg_in <= 32'h4000;
      wait_clk(3);
      chk({31'h0, debug_n_oe_out}, 32'h0);
      pulse_dbg(jtdp_pkg::DBG_INPUT);
      chk({24'h0, n_req}, 32'h0);
      sec_reg_in <= 32'h0;
      breakpoint_in <= 1'b0;
      for (int m = 0; m < 4; m++) begin
         pulse_dbg(2'(m));
         chk({24'h0, n_req}, 32'(m == 2));
      end
      complete_run();
   end
endmodule : tb
